// [src/dwp_core.sv]
// Behaviour
// - registered write starts a burst into the open row of bank on bank inputs
// - address bit 10 high on write closes the row when the burst ends
// - with on-the-fly enabled, bit 12 low gives four beats, high gives eight
// - a byte lane is stored only when its mask is low with that beat
// - write is cs low, ras high, cas low, we low with clock enable high
// - precharge closes bank or all banks, usable again after row-precharge time
// - precharge with bit 10 high hits all banks, else the addressed bank
// - precharge of idle or precharging bank is a no-op but restarts timing
// - each refresh with clock enable high advances an internal row counter and ignores address inputs; self refresh leaves the counter alone
// - refresh starts at registration and lasts the refresh cycle time
// - self refresh keeps data with no command clocking needed
// - deselect or nop registers nothing and leaves running work alone
// - idle only when banks closed, no burst, clock enable high, timers done
`timescale 1ns/1ns
`default_nettype none
module dwp_core
  import dwp_pkg::*;
#(
  parameter int DQ_BYTES = 2,
  parameter int DEPTH    = 32
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // command pins
  input  wire logic                    cke,
  input  wire logic                    cs_n,
  input  wire logic                    ras_n,
  input  wire logic                    cas_n,
  input  wire logic                    we_n,
  input  wire logic [BANK_W-1:0]       ba,
  input  wire logic [ADDR_W-1:0]       addr,
  // mode setting
  input  wire logic                    otf_enable,
  input  wire logic                    mode_full,
  // write data
  input  wire logic [DQ_BYTES*8-1:0]   dq,
  input  wire logic [DQ_BYTES-1:0]     dm,
  // array write port
  output logic                         arr_we,
  output logic      [BANK_W-1:0]       arr_bank,
  output logic      [ROW_W-1:0]        arr_row,
  output logic      [COL_W-1:0]        arr_col,
  output logic      [DQ_BYTES*8-1:0]   arr_data,
  output logic      [DQ_BYTES-1:0]     arr_lane_en,
  input  wire logic                    arr_ready,
  // refresh engine
  output logic                         refresh_busy,
  output logic      [ROW_W-1:0]        refresh_row,
  output logic                         self_refresh,
  // status
  output logic      [BANKS-1:0]        bank_open,
  output logic                         all_idle
);
  localparam int DW = DQ_BYTES*8;
  localparam int FW = DW + DQ_BYTES + BANK_W + ROW_W + COL_W;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    dwp_mode_t                    mode;
    logic                         cke_q;
    logic [BANKS-1:0]             open;
    logic [BANKS-1:0][ROW_W-1:0]  row;
    logic [BANKS-1:0][CNT_W-1:0]  trp;
    logic [CNT_W-1:0]             trfc;
    logic [3:0]                   beats;
    logic [BANK_W-1:0]            wbank;
    logic [COL_W-1:0]             wcol;
    logic                         wclose;
    logic [ROW_W-1:0]             rrow;
    logic                         we_o;
    logic [BANK_W-1:0]            bank_o;
    logic [ROW_W-1:0]             row_o;
    logic [COL_W-1:0]             col_o;
    logic [DW-1:0]                data_o;
    logic [DQ_BYTES-1:0]          lane_o;
    logic                         busy_o;
    logic                         self_o;
    logic                         idle_o;
  } dwp_state_t;

  dwp_state_t s;
  dwp_state_t next_s;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic [2:0] cmd;
  logic       valid_cmd;
  logic       is_act;
  logic       is_wr;
  logic       is_pre;
  logic       is_ref;
  logic       sre;
  logic       srx;
  logic       all_idle_c;
  logic       trp_done;

  assign cmd       = {ras_n, cas_n, we_n};
  // deselect and nop fall through as nothing
  assign valid_cmd = s.cke_q && cke && !cs_n;
  assign is_act    = valid_cmd && (cmd == CMD_ACT);
  assign is_wr     = valid_cmd && (cmd == CMD_WRITE);
  assign is_pre    = valid_cmd && (cmd == CMD_PRE);
  assign is_ref    = valid_cmd && (cmd == CMD_REF);
  assign sre       = s.cke_q && !cke && !cs_n && (cmd == CMD_REF) && all_idle_c;
  assign srx       = (s.mode == DWP_ST_SELF) && cke;

  always_comb begin
    trp_done = 1'b1;
    for (int i = 0; i < BANKS; i++) begin
      if (s.trp[i] != '0) trp_done = 1'b0;
    end
    all_idle_c = (s.open == '0) && (s.beats == '0) && s.cke_q
                 && trp_done && (s.trfc == '0);
  end

  // ------------------------------------------------------------
  // data buffer
  // ------------------------------------------------------------
  logic          f_in_valid;
  logic          f_in_ready;
  logic [FW-1:0] f_in_data;
  logic          f_out_valid;
  logic [FW-1:0] f_out_data;
  logic          f_pop;

  // masked lanes still pass; the drain side drops them per lane
  assign f_in_valid = (s.beats != '0);
  assign f_in_data  = {dq, dm, s.wbank, s.row[s.wbank], s.wcol};
  assign f_pop      = f_out_valid && arr_ready && !s.we_o;

  dwp_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .out_data  (f_out_data)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.cke_q = cke;
    next_s.we_o  = 1'b0;
    for (int i = 0; i < BANKS; i++) begin
      if (s.trp[i] != '0) next_s.trp[i] = s.trp[i] - 1'b1;
    end
    if (s.trfc != '0) next_s.trfc = s.trfc - 1'b1;

    // burst beats; a full fifo stalls capture, beat is held
    if (s.beats != '0 && f_in_ready) begin
      next_s.beats = s.beats - 4'h1;
      next_s.wcol  = s.wcol + 1'b1;
      if (s.beats == 4'h1 && s.wclose) begin
        next_s.open[s.wbank] = 1'b0;
        next_s.trp[s.wbank]  = CNT_W'(TRP_CYC);
      end
    end

    // drain to array, lane enables are inverted masks
    if (f_pop) begin
      next_s.we_o   = 1'b1;
      next_s.col_o  = f_out_data[COL_W-1:0];
      next_s.row_o  = f_out_data[COL_W +: ROW_W];
      next_s.bank_o = f_out_data[COL_W+ROW_W +: BANK_W];
      next_s.lane_o = ~f_out_data[COL_W+ROW_W+BANK_W +: DQ_BYTES];
      next_s.data_o = f_out_data[FW-1 -: DW];
    end

    case (s.mode)
      DWP_ST_IDLE, DWP_ST_BUSY: begin
        if (is_act && s.trp[ba] == '0) begin
          next_s.open[ba] = 1'b1;
          next_s.row[ba]  = addr[ROW_W-1:0];
        end
        if (is_wr && s.open[ba] && s.beats == '0) begin
          next_s.wbank  = ba;
          next_s.wcol   = COL_W'({addr[11], addr[9:0]});
          next_s.wclose = addr[A10_POS];
          next_s.beats  = (otf_enable ? addr[A12_POS] : mode_full)
                          ? 4'(BEATS_FULL) : 4'(BEATS_CHOP);
        end
        if (is_pre) begin
          for (int i = 0; i < BANKS; i++) begin
            if (addr[A10_POS] || ba == BANK_W'(i)) begin
              next_s.open[i] = 1'b0;
              next_s.trp[i]  = CNT_W'(TRP_CYC);
            end
          end
        end
        if (is_ref) begin
          next_s.mode = DWP_ST_RFSH;
          next_s.trfc = CNT_W'(TRFC_CYC);
          next_s.rrow = s.rrow + 1'b1;
        end else if (sre) begin
          next_s.mode = DWP_ST_SELF;
        end else begin
          // a command taken on this edge, or cke low, keeps the set busy
          next_s.mode = (all_idle_c && cke && !is_act && !is_pre)
                        ? DWP_ST_IDLE : DWP_ST_BUSY;
        end
      end
      DWP_ST_RFSH: begin
        // leave through busy so idle is judged afresh
        if (s.trfc == CNT_W'(1)) next_s.mode = DWP_ST_BUSY;
      end
      DWP_ST_SELF: begin
        if (srx) next_s.mode = DWP_ST_IDLE;
      end
      default: next_s.mode = DWP_ST_IDLE;
    endcase
    next_s.busy_o = (next_s.mode == DWP_ST_RFSH);
    next_s.self_o = (next_s.mode == DWP_ST_SELF);
    next_s.idle_o = (next_s.mode == DWP_ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s        <= '0;
      s.mode   <= DWP_ST_IDLE;
      s.idle_o <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign arr_we       = s.we_o;
  assign arr_bank     = s.bank_o;
  assign arr_row      = s.row_o;
  assign arr_col      = s.col_o;
  assign arr_data     = s.data_o;
  assign arr_lane_en  = s.lane_o;
  assign refresh_busy = s.busy_o;
  assign refresh_row  = s.rrow;
  assign self_refresh = s.self_o;
  assign bank_open    = s.open;
  assign all_idle     = s.idle_o;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_write_opens_burst: assert property (@(posedge clk) disable iff (reset)
    (is_wr && s.open[ba] && s.beats == '0 && s.mode != DWP_ST_RFSH) |=> (s.beats != '0))
    else $error("write did not start a burst");
  a_chop_length: assert property (@(posedge clk) disable iff (reset)
    (is_wr && s.open[ba] && s.beats == '0 && otf_enable && !addr[A12_POS]
     && s.mode != DWP_ST_RFSH) |=> (s.beats == 4'h4))
    else $error("chop burst length wrong");
  a_pre_closes: assert property (@(posedge clk) disable iff (reset)
    (is_pre && addr[A10_POS] && s.mode != DWP_ST_RFSH) |=> (s.open == '0))
    else $error("precharge all left a bank open");
  a_pre_timer: assert property (@(posedge clk) disable iff (reset)
    (is_pre && !addr[A10_POS] && s.mode != DWP_ST_RFSH) |=> (s.trp[$past(ba)] == CNT_W'(TRP_CYC)))
    else $error("precharge timer not restarted");
  a_refresh_len: assert property (@(posedge clk) disable iff (reset)
    (is_ref && s.mode != DWP_ST_RFSH && s.mode != DWP_ST_SELF) |=> refresh_busy[*2])
    else $error("refresh window too short");
  a_refresh_row: assert property (@(posedge clk) disable iff (reset)
    $rose(refresh_busy) |-> (s.rrow == $past(s.rrow) + 1'b1))
    else $error("refresh row not advanced");
  a_mask_lane: assert property (@(posedge clk) disable iff (reset)
    f_pop |=> (arr_lane_en == ~$past(f_out_data[COL_W+ROW_W+BANK_W +: DQ_BYTES])))
    else $error("masked lane enabled");
  a_nop_quiet: assert property (@(posedge clk) disable iff (reset)
    (cs_n && !(s.beats == 4'h1 && s.wclose)) |=> (s.open == $past(s.open)))
    else $error("deselect changed bank state");
  a_closed_write: assert property (@(posedge clk) disable iff (reset)
    (is_wr && !s.open[ba] && s.beats == '0) |=> (s.beats == '0))
    else $error("write to closed bank started a burst");
  a_refresh_blocks: assert property (@(posedge clk) disable iff (reset)
    (is_act && s.mode == DWP_ST_RFSH && !(s.beats == 4'h1 && s.wclose)) |=> (s.open == $past(s.open)))
    else $error("activate taken during refresh");
  a_idle_banks: assert property (@(posedge clk) disable iff (reset)
    all_idle |-> (s.open == '0 && s.beats == '0 && s.trfc == '0))
    else $error("idle flagged with work pending");
  a_self_entry: assert property (@(posedge clk) disable iff (reset)
    (sre && s.mode != DWP_ST_SELF && s.mode != DWP_ST_RFSH) |=> self_refresh)
    else $error("self refresh not entered");
  a_self_exit: assert property (@(posedge clk) disable iff (reset)
    (self_refresh && cke) |=> !self_refresh)
    else $error("self refresh not left");
endmodule : dwp_core
`default_nettype wire

// [shared/dwp_pkg.sv]
package dwp_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int BANKS       = 8;
  localparam int BANK_W      = 3;
  localparam int ROW_W       = 13;
  localparam int COL_W       = 10;
  localparam int ADDR_W      = 14;
  localparam int A10_POS     = 10;
  localparam int A12_POS     = 12;
  localparam int BEATS_FULL  = 8;
  localparam int BEATS_CHOP  = 4;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS      = 40;
  localparam int TRP_NS      = 15;
  localparam int TRFC_NS     = 110;
  localparam int TRP_CYC     = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRFC_CYC    = (TRFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 8;

  // ------------------------------------------------------------
  // command codes {ras_n, cas_n, we_n}
  // ------------------------------------------------------------
  localparam logic [2:0] CMD_ACT   = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRE   = 3'h2;
  localparam logic [2:0] CMD_REF   = 3'h1;

  typedef enum logic [1:0] {
    DWP_ST_IDLE = 2'b00,
    DWP_ST_BUSY = 2'b01,
    DWP_ST_RFSH = 2'b10,
    DWP_ST_SELF = 2'b11
  } dwp_mode_t;

endpackage : dwp_pkg

// [src/dwp_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
module dwp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (reset) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        mem[wp] <= in_data;
        wp      <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dwp_fifo
`default_nettype wire

// [test/dwp_ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dwp_ctrl_model
  import dwp_pkg::*;
#(
  parameter int DQ_BYTES = 2
) (
  // clock
  input  wire logic                  clk,
  // command pins
  output logic                       cke,
  output logic                       cs_n,
  output logic                       ras_n,
  output logic                       cas_n,
  output logic                       we_n,
  output logic      [BANK_W-1:0]     ba,
  output logic      [ADDR_W-1:0]     addr,
  // write data
  output logic      [DQ_BYTES*8-1:0] dq,
  output logic      [DQ_BYTES-1:0]   dm
);
  // refresh pacing held in clock counts; the bench refreshes by hand
  localparam int REFI_CYC = 195;

  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = '0;
    addr = '0;
    dq = '0;
    dm = '1;
  end

  // one command for one edge, then deselect
  task automatic cmd(input logic [2:0] code, input logic [BANK_W-1:0] b,
                     input logic [ADDR_W-1:0] a, input logic ck);
    @(negedge clk);
    cke = ck;
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = code;
    ba = b;
    addr = a;
    @(negedge clk);
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = ~b;
    addr = ~a;
  endtask : cmd

  task automatic beat(input logic [DQ_BYTES*8-1:0] d, input logic [DQ_BYTES-1:0] m);
    dq = d;
    dm = m;
    @(negedge clk);
  endtask : beat

  // released data lines must not keep showing the last beat
  task automatic release_dq;
    dq = ~dq;
    dm = ~dm;
  endtask : release_dq

  task automatic wake;
    @(negedge clk);
    cke = 1'b1;
  endtask : wake

  task automatic nop(input int n);
    repeat (n) @(negedge clk);
  endtask : nop
endmodule : dwp_ctrl_model
`default_nettype wire

// [test/tb_ddr3_write_precharge_refresh_cmds.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_ddr3_write_precharge_refresh_cmds;
  import dwp_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int DQB = 2;
  typedef logic [BANK_W+ROW_W+COL_W+DQB*9-1:0] dwp_word_t;
  logic                  clk        = 1'b0;
  logic                  reset;
  logic                  otf_enable;
  logic                  mode_full;
  logic                  arr_ready;
  wire logic             cke, cs_n, ras_n, cas_n, we_n;
  wire logic [BANK_W-1:0] ba;
  wire logic [ADDR_W-1:0] addr;
  wire logic [DQB*8-1:0] dq;
  wire logic [DQB-1:0]   dm;
  logic                  arr_we, refresh_busy, self_refresh, all_idle;
  logic      [BANK_W-1:0] arr_bank;
  logic      [ROW_W-1:0] arr_row, refresh_row, rr;
  logic      [COL_W-1:0] arr_col;
  logic      [DQB*8-1:0] arr_data;
  logic      [DQB-1:0]   arr_lane_en;
  logic      [BANKS-1:0] bank_open;
  logic      [ROW_W-1:0] open_row [BANKS];
  logic      [BANK_W-1:0] b;
  dwp_word_t             expq [$];
  int                    err_total  = 0;
  int                    num_checks = 0;
  int                    seed       = 32'hB761;
  int                    n;

  always #(CLK_NS / 2) clk = ~clk;

  dwp_ctrl_model #(.DQ_BYTES(DQB)) ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq(dq), .dm(dm));

  dwp_core #(.DQ_BYTES(DQB), .DEPTH(32)) dut (.clk(clk), .reset(reset), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .otf_enable(otf_enable), .mode_full(mode_full), .dq(dq), .dm(dm), .arr_we(arr_we),
    .arr_bank(arr_bank), .arr_row(arr_row), .arr_col(arr_col), .arr_data(arr_data),
    .arr_lane_en(arr_lane_en), .arr_ready(arr_ready), .refresh_busy(refresh_busy),
    .refresh_row(refresh_row), .self_refresh(self_refresh), .bank_open(bank_open),
    .all_idle(all_idle));

  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  function automatic int blen(input logic otf, input logic full, input logic a12);
    if (otf) return a12 ? BEATS_FULL : BEATS_CHOP;
    return full ? BEATS_FULL : BEATS_CHOP;
  endfunction : blen

  // sampled mid-cycle, away from the edge that launches the strobe
  always @(negedge clk) begin
    if (arr_we === 1'b1) begin
      if (expq.size() == 0) begin
        check(1, 0);
      end else begin
        check({arr_bank, arr_row, arr_col, arr_data, arr_lane_en}, expq.pop_front());
      end
    end
  end

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  task automatic wr_burst(input logic [BANK_W-1:0] wb, input logic [COL_W-1:0] c,
                          input logic a10, input logic a12, input logic live);
    logic [DQB*8-1:0] d;
    logic [DQB-1:0]   m;
    int               nb;
    nb = blen(otf_enable, mode_full, a12);
    ctl.cmd(CMD_WRITE, wb, {1'b0, a12, 1'b0, a10, c}, 1'b1);
    for (int i = 0; i < nb; i++) begin
      d = (DQB*8)'($random(seed));
      m = DQB'($random(seed));
      // a fully masked beat leaves nothing to observe at the array
      if (&m) m[0] = 1'b0;
      if (live) expq.push_back({wb, open_row[wb], c + COL_W'(i), d, ~m});
      ctl.beat(d, m);
    end
    ctl.release_dq();
  endtask : wr_burst

  task automatic drain;
    n = 0;
    while (expq.size() != 0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(expq.size(), 0);
  endtask : drain

  initial begin
    #(CLK_NS * 8000);
    err_total++;
    results();
  end

  initial begin
    reset = 1'b1;
    otf_enable = 1'b1;
    mode_full = 1'b1;
    arr_ready = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    ctl.nop(2);
    check(all_idle, 1);
    check(bank_open, 0);
    for (int i = 0; i < BANKS; i++) begin
      ctl.cmd(CMD_ACT, BANK_W'(i), 14'h0, 1'b1);
    end
    check(bank_open, 8'hFF);
    ctl.cmd(CMD_PRE, 3'h3, 14'h0, 1'b1);
    check(bank_open, 8'hF7);
    ctl.cmd(CMD_PRE, 3'h3, 14'h0, 1'b1);
    check(bank_open, 8'hF7);
    ctl.cmd(CMD_PRE, 3'h3, 14'h0400, 1'b1);
    ctl.nop(TRP_CYC + 1);
    check(bank_open, 0);
    check(all_idle, 1);
    rr = refresh_row;
    ctl.cmd(CMD_REF, 3'h5, 14'h3FFF, 1'b1);
    n = 0;
    while (refresh_busy === 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    check(n, TRFC_CYC);
    check(refresh_row, ROW_W'(rr + 1'b1));
    ctl.cmd(CMD_REF, 3'h0, 14'h0, 1'b1);
    ctl.cmd(CMD_ACT, 3'h2, 14'h0, 1'b1);
    check(bank_open, 0);
    ctl.nop(TRFC_CYC);
    ctl.cmd(CMD_REF, 3'h0, 14'h0, 1'b0);
    ctl.nop(20);
    check(self_refresh, 1);
    ctl.wake();
    ctl.nop(3);
    check(self_refresh, 0);
    ctl.nop(512);
    for (int k = 0; k < 16; k++) begin
      b = BANK_W'($random(seed));
      otf_enable = k[1];
      mode_full = k[2];
      open_row[b] = ROW_W'($random(seed));
      ctl.cmd(CMD_ACT, b, {1'b0, open_row[b]}, 1'b1);
      // random array back-pressure while the burst is captured
      arr_ready = 1'($random(seed));
      wr_burst(b, COL_W'($random(seed)), k[3], k[0], 1'b1);
      ctl.nop(TRP_CYC + 2);
      check(bank_open[b], !k[3]);
      if (!k[3]) ctl.cmd(CMD_PRE, b, 14'h0, 1'b1);
      ctl.nop(TRP_CYC + 1);
      arr_ready = 1'b1;
      drain();
    end
    // stall the array for exactly one buffer's worth of beats
    arr_ready <= 1'b0;
    otf_enable = 1'b1;
    open_row[6] = 13'h0055;
    ctl.cmd(CMD_ACT, 3'h6, 14'h0055, 1'b1);
    for (int k = 0; k < 4; k++) begin
      wr_burst(3'h6, COL_W'(k * 8), 1'b0, 1'b1, 1'b1);
    end
    ctl.nop(5);
    arr_ready <= 1'b1;
    drain();
    // second bank written just after the first has closed itself
    open_row[4] = 13'h1ABC;
    open_row[5] = 13'h0F0F;
    ctl.cmd(CMD_ACT, 3'h4, 14'h1ABC, 1'b1);
    ctl.cmd(CMD_ACT, 3'h5, 14'h0F0F, 1'b1);
    wr_burst(3'h4, 10'h3FE, 1'b1, 1'b0, 1'b1);
    wr_burst(3'h5, 10'h011, 1'b0, 1'b1, 1'b1);
    check(bank_open[5:4], 2'h2);
    drain();
    ctl.cmd(CMD_PRE, 3'h0, 14'h0400, 1'b1);
    ctl.nop(TRP_CYC + 1);
    wr_burst(3'h1, 10'h0, 1'b0, 1'b1, 1'b0);
    ctl.nop(20);
    results();
  end
endmodule : tb_ddr3_write_precharge_refresh_cmds
`default_nettype wire
